// >>> common/pir_params.svh
// Function
// R01: Setting the nesting-disable bit (bit 15 of control register 1) stops a pending interrupt from preempting a running handler; traps still preempt.
// R02: Every source has a software-written priority field, and all sources may share one non-zero level.
// R03: After reset every user source priority field holds level 4.
// R04: Software clears a source's pending flag before it sets that source's enable bit.
// R05: A request is forwarded only while its enable bit is 1; a 0 blocks it and leaves the flag alone.
// R06: A flag stays set until software clears it, so a still-set enabled flag requests again after return.
// R07: Return from interrupt restores the stacked low status byte and the previous CPU priority level.
// R08: Trap flags live in control register 1 and stay set until cleared, so an uncleared trap is taken again.
// R09: With the CPU level forced to 7 by ORing 0Eh into the low status byte, all user interrupts are masked.
// R10: Traps sit at levels 8 to 15 and nothing ever masks them; here traps use levels 8 to 11 and a CPU level at or above theirs holds them.
// R11: The timed disable masks levels 1 to 6 for its programmed count while level 7 still interrupts.
// R12: In enable register 1, bit 2 enables the comparator, bit 1 the I2C1 master and bit 0 the I2C1 slave interrupt.
// R13: The highest enabled, flagged source above the CPU level is presented; ties go to the lowest source number.
`ifndef PIR_PARAMS_SVH
`define PIR_PARAMS_SVH

// ----------------------------------------
// Sizes
// ----------------------------------------
`define PIR_NSRC        16
`define PIR_NTRAP       4
`define PIR_STK_DEPTH   8
`define PIR_TIMED_INTERRUPT_DISABLE_INSTR_W      14

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PIR_OFS_CTRL1   8'h00
`define PIR_OFS_FLAG    8'h04
`define PIR_OFS_ENA     8'h08
`define PIR_OFS_PRIO0   8'h0C
`define PIR_OFS_PRIO1   8'h10
`define PIR_OFS_CORE    8'h14
`define PIR_OFS_EVT     8'h18
`define PIR_OFS_MSK     8'h1C

// ----------------------------------------
// Fields and values
// ----------------------------------------
`define PIR_NESTING_DISABLE_BIT  15
`define PIR_TRAP_LSB    1
`define PIR_PRIO_RST    3'h4
`define PIR_IPL_LSB     1
`define PIR_IPL_MAX     3'h7
`define PIR_LVL_TRAP    4'h8
`define PIR_CMP_BIT     2
`define PIR_I2CM_BIT    1
`define PIR_I2CS_BIT    0
`define PIR_EVT_ACK     0
`define PIR_EVT_TRAP    1

`endif

// >>> common/pir_pkg.sv
`default_nettype none
`include "pir_params.svh"

package pir_pkg;

  // Core to controller strobes
  typedef struct packed {
    logic                     ack;
    logic                     ret;
    logic                     srl_we;
    logic [7:0]               srl_wdata;
    logic                     timed_interrupt_disable_instr_go;
    logic [`PIR_TIMED_INTERRUPT_DISABLE_INSTR_W-1:0]   timed_interrupt_disable_instr_cnt;
  } pir_core_in_t;

  // Controller to core request
  typedef struct packed {
    logic       req;
    logic       trap;
    logic [4:0] vec;
    logic [3:0] lvl;
  } pir_core_out_t;

  // Whole module state
  typedef struct packed {
    logic                                 dp_act;
    logic                                 dp_wr;
    logic [7:0]                           dp_addr;
    logic [31:0]                          rdata;
    logic                                 nesting_disable;
    logic [`PIR_NTRAP-1:0]                trap_flg;
    logic [`PIR_NSRC-1:0]                 flg;
    logic [`PIR_NSRC-1:0]                 ena;
    logic [`PIR_NSRC-1:0][2:0]            prio;
    logic [7:0]                           status_reg_low;
    logic                                 ipl3;
    logic [`PIR_STK_DEPTH-1:0][8:0]       stk;
    logic [3:0]                           depth;
    logic [`PIR_TIMED_INTERRUPT_DISABLE_INSTR_W-1:0]               timed_interrupt_disable_instr;
    logic [1:0]                           evt;
    logic [1:0]                           msk;
    pir_core_out_t                        co;
  } pir_state_t;

endpackage
`default_nettype wire

// >>> testbench/pir_core_bfm.sv
`timescale 1ns/1ps
`default_nettype none
module pir_core_bfm (
  // Clock
  input  wire logic            hclk,
  // Core strobes
  output pir_pkg::pir_core_in_t core_in
);
  initial core_in = '0;
  // One-cycle strobe after a stall of dly cycles
  task automatic go(input pir_pkg::pir_core_in_t v, input int dly);
    repeat (dly + 1) @(posedge hclk);
    core_in <= v;
    @(posedge hclk);
    core_in <= '0;
  endtask
endmodule
`default_nettype wire

// >>> testbench/pir_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
module pir_ctrl_props (
  // Clock, reset, bus answer
  input wire logic                   hclk,
  input wire logic                   hresetn,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  // Events and core side
  input wire logic [3:0]             trap_set,
  input wire pir_pkg::pir_core_in_t  core_in,
  input wire pir_pkg::pir_core_out_t core_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Bus answers at once and always okay
  a_zero_wait: assert property (hreadyout) else $error("wait state seen");
  a_resp_okay: assert property (!hresp) else $error("error response seen");
  // Request levels, masking and preemption
  a_trap_taken: assert property (|trap_set |-> ##[1:3] core_out.req && core_out.trap)
    else $error("trap not requested");
  a_trap_level: assert property (core_out.req && core_out.trap |-> core_out.lvl[3:2] == 2'h2)
    else $error("trap level wrong");
  a_user_level: assert property (core_out.req && !core_out.trap |-> core_out.lvl inside {[1:7]})
    else $error("user level wrong");
  a_timed_interrupt_disable_instr_mask: assert property (core_in.timed_interrupt_disable_instr_go && core_in.timed_interrupt_disable_instr_cnt > 14'h8 |->
    ##2 !(core_out.req && core_out.lvl < 4'h7) [*4]) else $error("timed disable leak");
  a_ipl_seven: assert property (core_in.srl_we && core_in.srl_wdata[3:1] == 3'h7 |->
    ##2 !(core_out.req && !core_out.trap) [*3]) else $error("level seven leak");
  a_ack_raise: assert property (core_out.req && core_in.ack |-> ##2
    (!core_out.req || core_out.trap || core_out.lvl > $past(core_out.lvl, 2))) else $error("no level raise");
endmodule
bind pir_ctrl pir_ctrl_props u_props (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .trap_set(trap_set), .core_in(core_in), .core_out(core_out));
`default_nettype wire

// >>> testbench/tb_prioritized_interrupt_controller.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("[FAIL] %0t %0h %0h", $time, g, e); end end

module tb_prioritized_interrupt_controller;
  localparam pir_pkg::pir_core_in_t ACK = '{ack: 1'b1, default: '0};
  localparam pir_pkg::pir_core_in_t RET = '{ret: 1'b1, default: '0};
  localparam pir_pkg::pir_core_in_t IPL7 = '{srl_we: 1'b1, srl_wdata: 8'h0E, default: '0};
  localparam pir_pkg::pir_core_in_t DIS = '{timed_interrupt_disable_instr_go: 1'b1, timed_interrupt_disable_instr_cnt: 14'h28, default: '0};
  logic                   hclk = 1'b0;
  logic                   hresetn = 1'b0;
  logic                   hwrite = 1'b0;
  logic [1:0]             htrans = 2'h0;
  logic [31:0]            haddr = 32'h0;
  logic [31:0]            hwdata = 32'h0;
  logic [15:0]            src_set = 16'h0;
  logic [3:0]             trap_set = 4'h0;
  logic                   hready;
  logic                   irq;
  logic [31:0]            hrdata;
  pir_pkg::pir_core_in_t  core_in;
  pir_pkg::pir_core_out_t core_out;
  int                     n_errors = 0;
  int                     num_checks = 0;
  int                     cyc = 0;
  pir_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(), .hrdata(hrdata),
    .src_set(src_set), .trap_set(trap_set), .core_in(core_in), .core_out(core_out), .irq(irq));
  pir_core_bfm u_core (.hclk(hclk), .core_in(core_in));
  // Clock and run limit
  initial forever #25 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      summarize();
    end
  end
  // Counts and verdict
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // One AHB word; a read is compared with d
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    if (!w) `CHK(hrdata, d)
  endtask
  // Event pulse, then request compared as {req, trap, vec, lvl}
  task automatic ev(input logic [15:0] s, input logic [3:0] t, input logic [10:0] e);
    @(posedge hclk);
    src_set  <= s;
    trap_set <= t;
    @(posedge hclk);
    src_set  <= 16'h0;
    trap_set <= 4'h0;
    repeat (2) @(posedge hclk);
    `CHK({core_out.req, core_out.trap, core_out.vec & {5{!core_out.trap}}, core_out.lvl} & {11{core_out.req}}, e)
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h0C, 32'h44444444);
    bus(1'b0, 8'h40, 32'h0);
    ev(16'h4, 4'h0, 11'h0);
    bus(1'b0, 8'h04, 32'h4);
    bus(1'b1, 8'h04, 32'hFFFF);
    bus(1'b1, 8'h08, 32'h7);
    bus(1'b0, 8'h08, 32'h7);
    ev(16'h5, 4'h0, 11'h404);
    u_core.go(ACK, 0);
    ev(16'h0, 4'h0, 11'h0);
    bus(1'b1, 8'h04, 32'h1);
    u_core.go(RET, 0);
    ev(16'h0, 4'h0, 11'h424);
    u_core.go(ACK, 3);
    u_core.go(RET, 0);
    ev(16'h0, 4'h0, 11'h424);
    u_core.go(ACK, 0);
    bus(1'b1, 8'h04, 32'h4);
    bus(1'b1, 8'h0C, 32'h44444764);
    bus(1'b1, 8'h00, 32'h8000);
    ev(16'h2, 4'h0, 11'h0);
    bus(1'b1, 8'h00, 32'h0);
    ev(16'h0, 4'h0, 11'h416);
    u_core.go(ACK, 0);
    bus(1'b1, 8'h04, 32'h2);
    u_core.go(RET, 0);
    u_core.go(RET, 0);
    u_core.go(DIS, 0);
    ev(16'h2, 4'h0, 11'h0);
    ev(16'h4, 4'h0, 11'h427);
    u_core.go(ACK, 0);
    bus(1'b1, 8'h04, 32'h6);
    u_core.go(RET, 0);
    u_core.go(IPL7, 0);
    ev(16'h4, 4'h0, 11'h0);
    ev(16'h0, 4'h2, 11'h609);
    u_core.go(ACK, 1);
    u_core.go(RET, 0);
    ev(16'h0, 4'h0, 11'h609);
    bus(1'b1, 8'h00, 32'h4);
    ev(16'h0, 4'h0, 11'h0);
    bus(1'b0, 8'h18, 32'h3);
    bus(1'b1, 8'h1C, 32'h1);
    @(posedge hclk);
    `CHK(irq, 1'b1)
    bus(1'b1, 8'h18, 32'h1);
    @(posedge hclk);
    `CHK(irq, 1'b0)
    bus(1'b0, 8'h18, 32'h2);
    summarize();
  end
endmodule
`default_nettype wire

// >>> verilog/pir_ctrl.sv
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pir_params.svh"

module pir_ctrl (
  // Clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  // Peripheral and trap event pulses
  input  wire logic [`PIR_NSRC-1:0]   src_set,
  input  wire logic [`PIR_NTRAP-1:0]  trap_set,
  // Core side
  input  wire pir_pkg::pir_core_in_t  core_in,
  output pir_pkg::pir_core_out_t      core_out,
  output logic                        irq
);

  pir_pkg::pir_state_t s_r;
  pir_pkg::pir_state_t s_nxt;

  // ----------------------------------------
  // Functions
  // ----------------------------------------

  // Pack eight priority fields into one word
  function automatic logic [31:0] prio_word(input logic [`PIR_NSRC-1:0][2:0] p, input int base);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int k = 0; k < 8; k++) begin
      w[4*k +: 3] = p[base+k];
    end
    return w;
  endfunction

  // Register read decode
  function automatic logic [31:0] rd(input pir_pkg::pir_state_t s, input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      `PIR_OFS_CTRL1: begin
        w[`PIR_NESTING_DISABLE_BIT] = s.nesting_disable;
        w[`PIR_TRAP_LSB +: `PIR_NTRAP] = s.trap_flg;
      end
      `PIR_OFS_FLAG:  w[`PIR_NSRC-1:0] = s.flg;
      `PIR_OFS_ENA:   w[`PIR_NSRC-1:0] = s.ena;
      `PIR_OFS_PRIO0: w = prio_word(s.prio, 0);
      `PIR_OFS_PRIO1: w = prio_word(s.prio, 8);
      `PIR_OFS_CORE:  w = {4'h0, s.depth, 1'b0, s.ipl3, s.status_reg_low, s.timed_interrupt_disable_instr};
      `PIR_OFS_EVT:   w[1:0] = s.evt;
      `PIR_OFS_MSK:   w[1:0] = s.msk;
      default:        w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // Arbitration over the updated state
  function automatic pir_pkg::pir_core_out_t arb(input pir_pkg::pir_state_t s);
    pir_pkg::pir_core_out_t o;
    logic [3:0] cur;
    logic [2:0] lv;
    logic       blk;
    o   = '0;
    cur = {s.ipl3, s.status_reg_low[`PIR_IPL_LSB +: 3]};
    // Traps, highest index first, held off only while the CPU level is at or above their own
    for (int t = 0; t < `PIR_NTRAP; t++) begin
      if (s.trap_flg[t] && (`PIR_LVL_TRAP + 4'(t)) > cur && !(o.req && o.lvl > `PIR_LVL_TRAP + 4'(t))) begin // R08 R10
        o.req  = 1'b1;
        o.trap = 1'b1;
        o.vec  = 5'(t);
        o.lvl  = `PIR_LVL_TRAP + 4'(t);
      end
    end
    // Nesting disable holds off user sources inside a handler
    blk = s.nesting_disable && (s.depth != 4'h0); // R01
    if (!o.req && !blk) begin
      for (int i = `PIR_NSRC-1; i >= 0; i--) begin
        lv = s.prio[i];
        if (s.flg[i] && s.ena[i] && lv != 3'h0 // R05 R06
            && {1'b0, lv} > cur // R09
            && !(s.timed_interrupt_disable_instr != '0 && lv != `PIR_IPL_MAX) // R11
            && !(o.req && o.lvl[2:0] > lv)) begin // R13
          o.req = 1'b1;
          o.vec = 5'(i);
          o.lvl = {1'b0, lv};
        end
      end
    end
    return o;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------

  // Bus, flags, core strobes and arbitration
  always_comb begin
    s_nxt = s_r;
    // Address phase capture, read data prepared for the data phase
    s_nxt.dp_act = hsel && hready && htrans[1];
    s_nxt.dp_wr  = hwrite;
    s_nxt.dp_addr = haddr[7:0];
    s_nxt.rdata  = rd(s_r, haddr[7:0]);
    // Data phase writes
    if (s_r.dp_act && s_r.dp_wr) begin
      case (s_r.dp_addr)
        `PIR_OFS_CTRL1: begin
          s_nxt.nesting_disable   = hwdata[`PIR_NESTING_DISABLE_BIT]; // R01
          s_nxt.trap_flg = s_r.trap_flg & ~hwdata[`PIR_TRAP_LSB +: `PIR_NTRAP]; // R08
        end
        `PIR_OFS_FLAG:  s_nxt.flg = s_r.flg & ~hwdata[`PIR_NSRC-1:0]; // R06
        `PIR_OFS_ENA:   s_nxt.ena = hwdata[`PIR_NSRC-1:0]; // R05 R12
        `PIR_OFS_PRIO0: for (int k = 0; k < 8; k++) s_nxt.prio[k] = hwdata[4*k +: 3]; // R02
        `PIR_OFS_PRIO1: for (int k = 0; k < 8; k++) s_nxt.prio[8+k] = hwdata[4*k +: 3]; // R02
        `PIR_OFS_EVT:   s_nxt.evt = s_r.evt & ~hwdata[1:0];
        `PIR_OFS_MSK:   s_nxt.msk = hwdata[1:0];
        default: ;
      endcase
    end
    // Hardware sets win over clears
    s_nxt.flg      = s_nxt.flg | src_set;
    s_nxt.trap_flg = s_nxt.trap_flg | trap_set;
    if (|trap_set) s_nxt.evt[`PIR_EVT_TRAP] = 1'b1;
    // Software write of the low status byte
    if (core_in.srl_we) s_nxt.status_reg_low = core_in.srl_wdata; // R09
    // Timed disable countdown
    if (core_in.timed_interrupt_disable_instr_go) s_nxt.timed_interrupt_disable_instr = core_in.timed_interrupt_disable_instr_cnt; // R11
    else if (s_r.timed_interrupt_disable_instr != '0) s_nxt.timed_interrupt_disable_instr = s_r.timed_interrupt_disable_instr - 1'b1; // R11
    // Accept: stack old level, raise to request level
    if (s_r.co.req && core_in.ack && s_r.depth != 4'(`PIR_STK_DEPTH)) begin
      s_nxt.stk[s_r.depth[2:0]] = {s_nxt.ipl3, s_nxt.status_reg_low};
      s_nxt.depth = s_r.depth + 4'h1;
      s_nxt.ipl3  = s_r.co.lvl[3];
      s_nxt.status_reg_low[`PIR_IPL_LSB +: 3] = s_r.co.lvl[2:0];
      s_nxt.evt[`PIR_EVT_ACK] = 1'b1;
    end else if (core_in.ret && s_r.depth != 4'h0) begin
      // Return: restore status byte and prior level
      {s_nxt.ipl3, s_nxt.status_reg_low} = s_r.stk[s_r.depth[2:0] - 3'h1]; // R07
      s_nxt.depth = s_r.depth - 4'h1;
    end
    s_nxt.co = arb(s_nxt); // R13
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------

  // Reset values, priorities at level 4
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      for (int i = 0; i < `PIR_NSRC; i++) s_r.prio[i] <= `PIR_PRIO_RST; // R03
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_r.rdata;
  assign core_out  = s_r.co;
  assign irq       = |(s_r.evt & s_r.msk);

endmodule
`default_nettype wire
